/* hw/fswp_top.sv */
// Local design decision: the APB register port.
`timescale 1ns/1ps
module fswp_top #(
  parameter int unsigned SECTORS = fswp_pkg::SECTORS_MAX,
  parameter int unsigned PAGE_W = 8,
  parameter int unsigned PAGE_SECT_SHIFT = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fswp_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PAGE_W-1:0] page_select,
  output logic [7:0] sector_lock,
  output logic flash_unlocked,
  output logic erase_req,
  output logic [PAGE_W-1:0] erase_page
);
  import fswp_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // Shared by read and write paths
  function automatic logic addr_hit(input logic [APB_AW-1:0] a, input logic [11:0] idx);
    return a == fswp_byte_addr(idx);
  endfunction

  logic hit_cmd;
  logic hit_shared;
  logic hit_any;

  // Two mapped words, everything else is an error
  assign hit_cmd = addr_hit(paddr, CMD_IDX);
  assign hit_shared = addr_hit(paddr, SHARED_IDX);
  assign hit_any = hit_cmd | hit_shared;

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_fire;
  logic rd_setup;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  // Low byte lane carries every register
  assign wr_fire = access_ph & pwrite & hit_any & pstrb[0];
  assign rd_setup = setup_ph & ~pwrite;
  assign pslverr = access_ph & ~hit_any;

  // ----------------------------------------
  // Write steering
  // ----------------------------------------
  logic cmd_wr;
  logic shared_wr;
  logic lock_wr;
  logic page_wr;
  logic armed;
  logic erase_try;
  fswp_state_t cmd_state;

  assign cmd_wr = wr_fire & hit_cmd;
  assign shared_wr = wr_fire & hit_shared;
  // Exactly one target per shared write
  assign lock_wr = shared_wr & armed;
  assign page_wr = shared_wr & ~armed;

  // Command sequencer and arming flag
  fswp_cmd_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .cmd_wr(cmd_wr),
    .cmd_code(pwdata[7:0]),
    .shared_wr(shared_wr),
    .state(cmd_state),
    .armed(armed),
    .erase_try(erase_try)
  );

  // Sticky sector lock bits
  fswp_lock_reg #(
    .SECTORS(SECTORS)
  ) u_lock (
    .pclk(pclk),
    .presetn(presetn),
    .set_wr(lock_wr),
    .set_data(pwdata[7:0]),
    .lock(sector_lock)
  );

  // ----------------------------------------
  // Page select register
  // ----------------------------------------
  logic [PAGE_W-1:0] page_r;
  logic [PAGE_W-1:0] page_nxt;

  // Updated only when the shared write is not diverted
  always_comb begin
    page_nxt = page_r;
    if (page_wr) begin
      page_nxt = pwdata[PAGE_W-1:0];
    end
  end

  // Page select storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_r <= PAGE_RESET[PAGE_W-1:0];
    end else begin
      page_r <= page_nxt;
    end
  end

  assign page_select = page_r;

  // ----------------------------------------
  // Page erase issue
  // ----------------------------------------
  logic [2:0] page_sector;
  logic page_locked;
  logic erase_r;
  logic erase_nxt;
  logic [PAGE_W-1:0] epage_r;
  logic [PAGE_W-1:0] epage_nxt;
  logic blocked_r;
  logic blocked_nxt;

  // Sector that holds the selected page
  assign page_sector = 3'(page_r >> PAGE_SECT_SHIFT);
  assign page_locked = sector_lock[page_sector];

  // A protected sector refuses the erase; the refusal is kept for status
  always_comb begin
    erase_nxt = 1'b0;
    epage_nxt = epage_r;
    blocked_nxt = blocked_r;
    if (erase_try) begin
      blocked_nxt = page_locked;
      if (!page_locked) begin
        erase_nxt = 1'b1;
        epage_nxt = page_r;
      end
    end
  end

  // Erase pulse and its page
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_r <= 1'b0;
      epage_r <= PAGE_RESET[PAGE_W-1:0];
      blocked_r <= 1'b0;
    end else begin
      erase_r <= erase_nxt;
      epage_r <= epage_nxt;
      blocked_r <= blocked_nxt;
    end
  end

  assign erase_req = erase_r;
  assign erase_page = epage_r;
  assign flash_unlocked = (cmd_state == FSWP_OPEN);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [7:0] status_word;

  // Controller state, arming and last erase refusal
  always_comb begin
    status_word = 8'h00;
    status_word[STAT_STATE_LSB +: 2] = cmd_state;
    status_word[STAT_ARMED_BIT] = armed;
    status_word[STAT_BLOCKED_BIT] = blocked_r;
  end

  // Captured in setup so the access phase returns a stable flop value;
  // the shared word reads back whichever register a write would reach
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_setup) begin
      rdata_nxt = 32'h0000_0000;
      if (hit_cmd) begin
        rdata_nxt[7:0] = status_word;
      end else if (hit_shared && armed) begin
        rdata_nxt[7:0] = sector_lock;
      end else if (hit_shared) begin
        rdata_nxt[PAGE_W-1:0] = page_r;
      end
    end
  end

  // Read data holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata = rdata_r;

endmodule // fswp_top

/* shared/fswp_pkg.sv */
// What this block does
// - One shared register address feeds both page select and sector lock.
// - Locked controller given code 5EH steers the next shared write to the lock.
// - Without that arming, shared-address writes land in page select.
// - Eight lock bits, bit x guards sector x, set means protected.
// - All lock bits are zero after reset.
// - A set lock bit cannot be cleared until the next reset.
// - Mid-size variant: upper four lock bits unimplemented, no effect.
// - Smallest variant: upper six lock bits unimplemented, no effect.
// - Unknown code or wrong order returns the controller to locked.
// - Page erase acts only on the page held in page select.
package fswp_pkg;

  // ----------------------------------------
  // Register map (index, byte address is 4x)
  // ----------------------------------------
  localparam int unsigned APB_AW = 16;
  localparam logic [11:0] CMD_IDX = 12'hFF8;
  localparam logic [11:0] SHARED_IDX = 12'hFF9;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CODE_UNLOCK1 = 8'h73;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h8C;
  localparam logic [7:0] CODE_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CODE_MASS_ERASE = 8'h63;
  localparam logic [7:0] CODE_LOCK_ACCESS = 8'h5E;

  // ----------------------------------------
  // Reset values and widths
  // ----------------------------------------
  localparam int unsigned SECTORS_MAX = 8;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // ----------------------------------------
  // Status word fields (read at the command index)
  // ----------------------------------------
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_ARMED_BIT = 2;
  localparam int unsigned STAT_BLOCKED_BIT = 3;

  typedef enum logic [1:0] {
    FSWP_LOCKED,
    FSWP_FIRST,
    FSWP_OPEN
  } fswp_state_t;

  // Index to APB byte address
  function automatic logic [APB_AW-1:0] fswp_byte_addr(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

endpackage

/* hw/fswp_lock_reg.sv */
`timescale 1ns/1ps
module fswp_lock_reg #(
  parameter int unsigned SECTORS = fswp_pkg::SECTORS_MAX
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_wr,
  input wire logic [7:0] set_data,
  output logic [7:0] lock
);
  import fswp_pkg::*;

  // ----------------------------------------
  // One sticky bit per implemented sector
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      if (i < SECTORS) begin : g_impl
        logic bit_r;
        logic bit_nxt;
        // Only ever sets; a zero write is ignored
        always_comb begin
          bit_nxt = bit_r | (set_wr & set_data[i]);
        end
        // Cleared only by reset
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            bit_r <= LOCK_RESET[i];
          end else begin
            bit_r <= bit_nxt;
          end
        end
        assign lock[i] = bit_r;
      end else begin : g_none
        // Absent sector in small parts
        assign lock[i] = 1'b0;
      end
    end
  endgenerate

endmodule // fswp_lock_reg

/* hw/fswp_cmd_seq.sv */
`timescale 1ns/1ps
module fswp_cmd_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic shared_wr,
  output fswp_pkg::fswp_state_t state,
  output logic armed,
  output logic erase_try
);
  import fswp_pkg::*;

  fswp_state_t state_r;
  fswp_state_t state_nxt;
  logic armed_r;
  logic armed_nxt;

  // ----------------------------------------
  // Unlock sequence and lock-access arming
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    armed_nxt = armed_r;
    erase_try = 1'b0;
    if (cmd_wr) begin
      state_nxt = FSWP_LOCKED;
      armed_nxt = 1'b0;
      unique case (state_r)
        FSWP_LOCKED: begin
          if (cmd_code == CODE_UNLOCK1) begin
            state_nxt = FSWP_FIRST;
          end else if (cmd_code == CODE_LOCK_ACCESS) begin
            armed_nxt = 1'b1;
          end
        end
        FSWP_FIRST: begin
          if (cmd_code == CODE_UNLOCK2) begin
            state_nxt = FSWP_OPEN;
          end
        end
        FSWP_OPEN: begin
          // Mass erase is debugger-only, so it falls to locked
          if (cmd_code == CODE_PAGE_ERASE) begin
            erase_try = 1'b1;
          end
        end
      endcase
    end else if (shared_wr) begin
      armed_nxt = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FSWP_LOCKED;
      armed_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      armed_r <= armed_nxt;
    end
  end

  assign state = state_r;
  assign armed = armed_r;

endmodule // fswp_cmd_seq

/* sim/fswp_sva.sv */
`timescale 1ns/1ps
module fswp_sva
  import fswp_pkg::*;
#(
  parameter int unsigned SECTORS = 8,
  parameter int unsigned PAGE_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fswp_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic [PAGE_W-1:0] page_select,
  input wire logic [7:0] sector_lock,
  input wire logic flash_unlocked,
  input wire logic erase_req,
  input wire logic [PAGE_W-1:0] erase_page
);
  // ----------------------------
  // Taken writes
  // ----------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Low byte strobe gates every write
  wire logic wr = psel && penable && pwrite && pstrb[0];
  wire logic wr_cmd = wr && (paddr == {2'b00, CMD_IDX, 2'b00});
  wire logic wr_shr = wr && (paddr == {2'b00, SHARED_IDX, 2'b00});

  // ----------------------------
  // Checks
  // ----------------------------
  one_target_a: assert property (
    $changed(sector_lock) |-> $stable(page_select) && $past(wr_shr))
    else $error("lock moved without a lone shared write");
  page_cause_a: assert property ($changed(page_select) |-> $past(wr_shr))
    else $error("page select moved without a shared write");
  lock_sticky_a: assert property ((sector_lock & $past(sector_lock)) == $past(sector_lock))
    else $error("a set lock bit was cleared");
  lock_width_a: assert property ((sector_lock >> SECTORS) == 8'h00)
    else $error("unimplemented lock bit set");
  lock_reset_a: assert property ($rose(presetn) |-> sector_lock == 8'h00)
    else $error("lock bits not clear after reset");
  unlock_seq_a: assert property (
    $rose(flash_unlocked) |-> $past(wr_cmd && pwdata[7:0] == CODE_UNLOCK2))
    else $error("unlocked without second unlock code");
  relock_a: assert property (wr_cmd && flash_unlocked |=> !flash_unlocked)
    else $error("controller stayed open after a command");
  erase_page_a: assert property (erase_req |-> erase_page == $past(page_select))
    else $error("erase page differs from page select");
  erase_one_a: assert property (erase_req |=> !erase_req)
    else $error("erase pulse longer than one cycle");
  cover property (erase_req);
  cover property ($rose(flash_unlocked));
  cover property ($changed(sector_lock));
endmodule // fswp_sva

bind fswp_top fswp_sva #(.SECTORS(SECTORS), .PAGE_W(PAGE_W)) fswp_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
  .page_select(page_select), .sector_lock(sector_lock), .flash_unlocked(flash_unlocked),
  .erase_req(erase_req), .erase_page(erase_page));

/* sim/fswp_tb_top.sv */
`timescale 1ns/1ps
module fswp_tb_top;
  import fswp_pkg::*;
  localparam logic [15:0] CMD_A = {2'b00, CMD_IDX, 2'b00};
  localparam logic [15:0] SHR_A = {2'b00, SHARED_IDX, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata [3];
  logic pready [3];
  logic pslverr [3];
  logic [7:0] page_select [3];
  logic [7:0] sector_lock [3];
  logic flash_unlocked [3];
  logic erase_req [3];
  logic [7:0] erase_page [3];
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int total_checks = 0;

  // ----------------------------
  // Clock and devices
  // ----------------------------
  always #10 pclk = ~pclk;
  // Full, mid and smallest variants share one bus
  for (genvar g = 0; g < 3; g++) begin : g_var
    fswp_top #(.SECTORS(8 >> g)) fswp_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata[g]),
      .pready(pready[g]), .pslverr(pslverr[g]), .page_select(page_select[g]),
      .sector_lock(sector_lock[g]), .flash_unlocked(flash_unlocked[g]),
      .erase_req(erase_req[g]), .erase_page(erase_page[g]));
  end

  // ----------------------------
  // Tasks
  // ----------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read data and error taken only at the edge that sees pready
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready[0] !== 1'b1);
    rd = prdata[0];
    er = pslverr[0];
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // Smaller variants keep only their low bits
  task automatic lk(input logic [7:0] e);
    chk(sector_lock[0], e);
    chk(sector_lock[1], e & 8'h0F);
    chk(sector_lock[2], e & 8'h03);
  endtask

  task automatic t_lock;
    chk(page_select[0], 32'h0);
    lk(8'h00);
    apb(1'b1, SHR_A, 8'h2A);
    chk(page_select[0], 32'h2A);
    lk(8'h00);
    apb(1'b1, CMD_A, 8'h5E);
    apb(1'b1, SHR_A, 8'hF1);
    lk(8'hF1);
    chk(page_select[0], 32'h2A);
    apb(1'b1, SHR_A, 8'h10);
    chk(page_select[0], 32'h10);
    lk(8'hF1);
    apb(1'b1, CMD_A, 8'h5E);
    apb(1'b1, SHR_A, 8'h02);
    lk(8'hF3);
    apb(1'b1, CMD_A, CODE_LOCK_ACCESS);
    apb(1'b0, CMD_A, 8'h00);
    chk(rd, 32'h1 << STAT_ARMED_BIT);
    apb(1'b0, SHR_A, 8'h00);
    chk(rd, 32'hF3);
    apb(1'b1, SHR_A, 8'h00);
    lk(8'hF3);
    chk(page_select[0], 32'h10);
    apb(1'b0, SHR_A, 8'h00);
    chk(rd, 32'h10);
    apb(1'b0, 16'h0000, 8'h00);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test lock done");
  endtask

  // Wrong order, unlock, erase, mass erase code
  task automatic t_cmd;
    apb(1'b1, CMD_A, CODE_UNLOCK1);
    apb(1'b1, CMD_A, CODE_PAGE_ERASE);
    chk({31'h0, erase_req[0]}, 32'h0);
    apb(1'b1, CMD_A, CODE_UNLOCK1);
    apb(1'b1, CMD_A, CODE_UNLOCK2);
    chk({31'h0, flash_unlocked[0]}, 32'h1);
    apb(1'b1, CMD_A, CODE_PAGE_ERASE);
    chk({31'h0, erase_req[0]}, 32'h1);
    chk(erase_page[0], 32'h10);
    chk({31'h0, flash_unlocked[0]}, 32'h0);
    apb(1'b1, CMD_A, CODE_UNLOCK1);
    apb(1'b1, CMD_A, CODE_UNLOCK2);
    apb(1'b1, CMD_A, CODE_MASS_ERASE);
    chk({31'h0, flash_unlocked[0]}, 32'h0);
    $display("test command done");
  endtask

  // Only a reset may clear set lock bits
  task automatic t_rst;
    apb(1'b1, CMD_A, CODE_LOCK_ACCESS);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    lk(8'h00);
    chk({31'h0, flash_unlocked[0]}, 32'h0);
    // Reset must also drop the arming, so this lands in page select
    apb(1'b1, SHR_A, 8'h33);
    chk(page_select[0], 32'h33);
    lk(8'h00);
    $display("test reset done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------
  // Sequence and watchdog
  // ----------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_lock;
    t_cmd;
    t_rst;
    end_of_test;
  end
  // Whole run is under two microseconds; this is far past it
  initial begin
    #100000;
    err_count++;
    end_of_test;
  end
endmodule // fswp_tb_top
